// ==== design/apc_top.sv ====
// Summary of operation
// R1: a direction bit of 0 makes the pin an input and 1 makes the block drive it as an output.
// R2: for an input the polarity bit picks the asserted level, 0 for low and 1 for high.
// R3: in level mode the pin's state bit is 1 exactly while the pin sits at its asserted level.
// R4: in edge mode the state bit latches to 1 once the pin has been asserted and holds there.
// R5: in edge mode a read of the state register clears the latched bit, keeping later assertions.
// R6: an output pin with output-state bit 0 is driven low.
// R7: an output pin with output-state bit 1 is driven high.
// R8: at reset and on suspend pins 4 and 5 return to output direction driving high.
// R9: at reset and on suspend pin 3 returns to input direction.
// R10: polarity and sensing act only on inputs and output-state acts only on outputs.
`timescale 1ns/1ns

module apc_top (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        suspend_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [4:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    output logic             irq_o,
    input  wire logic [2:0]  pin_i,
    output logic [2:0]       pin_o,
    output logic [2:0]       pin_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // true when the access addresses the given word
    function automatic logic hit(input logic [4:0] adr, input logic [4:0] ofs);
        hit = (adr[4:2] == ofs[4:2]);
    endfunction : hit

    // asserted level of an input pin under its polarity
    function automatic logic asserted(input logic lvl, input logic pol_high);
        asserted = pol_high ? lvl : ~lvl;
    endfunction : asserted

    // true for a write that carries byte lane 0 to the given word
    function automatic logic lane0_wr(input logic wr, input logic [3:0] sel,
                                      input logic [4:0] adr, input logic [4:0] ofs);
        lane0_wr = wr & sel[0] & hit(adr, ofs);
    endfunction : lane0_wr

    // settings of one pin after reset or suspend
    function automatic apc_pkg::apc_pin_cfg_s dflt_cfg(input int unsigned idx);
        logic [11:0] nibs;
        nibs     = {apc_pkg::RST_CTL5[3:0], apc_pkg::RST_CTL34};
        dflt_cfg = apc_pkg::apc_pin_cfg_s'(nibs[idx*apc_pkg::NIB_W +: apc_pkg::NIB_W]);
    endfunction : dflt_cfg

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0]               ctl34_r;
    logic [7:0]               ctl5_r;
    logic [7:0]               ctl34_nxt;
    logic [7:0]               ctl5_nxt;
    apc_pkg::apc_pin_cfg_s    cfg [apc_pkg::NPIN];
    logic [2:0]               state_r;
    logic [2:0]               state_nxt;
    logic [2:0]               act_now;
    logic [2:0]               act_prev_r;
    logic [2:0]               rise;
    logic [2:0]               flag_r;
    logic [2:0]               flag_nxt;
    logic [2:0]               mask_r;
    logic [2:0]               pin_o_r;
    logic [2:0]               pin_oe_r;
    logic [31:0]              rdata;
    logic                     req;
    logic                     wr_stb;
    logic                     rd_stb;
    logic                     rd_state;
    logic                     rd_flag;
    logic                     wr_ctl34;
    logic                     wr_ctl5;
    logic                     wr_mask;
    logic                     irq_nxt;
    apc_pkg::apc_bus_e        bus_r;

    ////////////////////////////////////////////////////////////////////////////
    // wishbone handshake: answer one cycle after the request, then drop

    assign req    = cyc_i & stb_i & (bus_r == apc_pkg::APC_IDLE);
    assign wr_stb = req & we_i;
    assign rd_stb = req & ~we_i;

    // one strobe per writable word, byte lane 0 only
    assign wr_ctl34 = lane0_wr(wr_stb, sel_i, adr_i, apc_pkg::OFS_CTL34);
    assign wr_ctl5  = lane0_wr(wr_stb, sel_i, adr_i, apc_pkg::OFS_CTL5);
    assign wr_mask  = lane0_wr(wr_stb, sel_i, adr_i, apc_pkg::OFS_IRQMK);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_r <= apc_pkg::APC_IDLE;
        end else begin
            case (bus_r)
                apc_pkg::APC_IDLE: begin
                    if (cyc_i && stb_i) begin
                        bus_r <= apc_pkg::APC_ACK;
                    end
                end
                apc_pkg::APC_ACK: begin
                    bus_r <= apc_pkg::APC_IDLE;
                end
                default: begin
                    bus_r <= apc_pkg::APC_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control registers, byte lane 0 only; suspend reloads the defaults

    always_comb begin
        ctl34_nxt = ctl34_r;
        ctl5_nxt  = ctl5_r;
        if (wr_ctl34) begin
            ctl34_nxt = dat_i[7:0];
        end
        if (wr_ctl5) begin
            // upper nibble has no pin behind it and reads zero
            ctl5_nxt = {4'h0, dat_i[3:0]};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || suspend_i) begin
            ctl34_r <= apc_pkg::RST_CTL34; // [R8] [R9]
        end else begin
            ctl34_r <= ctl34_nxt;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || suspend_i) begin
            ctl5_r <= apc_pkg::RST_CTL5; // [R8]
        end else begin
            ctl5_r <= ctl5_nxt;
        end
    end

    assign cfg[0] = apc_pkg::apc_pin_cfg_s'(ctl34_r[3:0]);
    assign cfg[1] = apc_pkg::apc_pin_cfg_s'(ctl34_r[7:4]);
    assign cfg[2] = apc_pkg::apc_pin_cfg_s'(ctl5_r[3:0]);

    ////////////////////////////////////////////////////////////////////////////
    // interrupt mask

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_r <= apc_pkg::RST_MASK;
        end else if (wr_mask) begin
            mask_r <= dat_i[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-pin sensing and drive

    assign rd_state = rd_stb & hit(adr_i, apc_pkg::OFS_STATE);
    assign rd_flag  = rd_stb & hit(adr_i, apc_pkg::OFS_IRQST);

    for (genvar g = 0; g < apc_pkg::NPIN; g++) begin : g_pin
        // sensing only counts while the pin is an input
        assign act_now[g] = ~cfg[g].dir_out
                            & asserted(pin_i[g], cfg[g].pol_high); // [R1] [R2] [R10]
        assign rise[g]    = act_now[g] & ~act_prev_r[g];

        always_comb begin
            if (cfg[g].dir_out) begin
                state_nxt[g] = 1'b0; // [R10]
            end else if (!cfg[g].edge_sns) begin
                state_nxt[g] = act_now[g]; // [R3]
            end else begin
                // a new assertion wins over the clear by read
                state_nxt[g] = act_now[g]
                               | (state_r[g] & ~rd_state); // [R4] [R5]
            end
        end

        always_comb begin
            // a new event wins over the clear by read
            flag_nxt[g] = rise[g] | (flag_r[g] & ~rd_flag);
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                act_prev_r[g] <= apc_pkg::RST_FLAGS[g];
            end else begin
                act_prev_r[g] <= act_now[g];
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                state_r[g] <= apc_pkg::RST_FLAGS[g];
            end else begin
                state_r[g] <= state_nxt[g];
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                flag_r[g] <= apc_pkg::RST_FLAGS[g];
            end else begin
                flag_r[g] <= flag_nxt[g];
            end
        end

        // the pin keeps its power-on drive while reset is held
        localparam apc_pkg::apc_pin_cfg_s DFLT = dflt_cfg(g);

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pin_oe_r[g] <= DFLT.dir_out; // [R8] [R9]
            end else begin
                pin_oe_r[g] <= cfg[g].dir_out; // [R1]
            end
        end

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                pin_o_r[g] <= DFLT.dir_out & DFLT.out_lvl; // [R8]
            end else begin
                // level only reaches the pin while it is an output
                pin_o_r[g] <= cfg[g].dir_out & cfg[g].out_lvl; // [R6] [R7] [R10]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: high while an unmasked event flag is set

    always_comb begin
        irq_nxt = |(flag_nxt & mask_r);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data; unmapped words read zero

    always_comb begin
        rdata = 32'h0000_0000;
        if (hit(adr_i, apc_pkg::OFS_CTL34)) begin
            rdata[7:0] = ctl34_r;
        end else if (hit(adr_i, apc_pkg::OFS_CTL5)) begin
            rdata[7:0] = ctl5_r;
        end else if (hit(adr_i, apc_pkg::OFS_STATE)) begin
            rdata[2:0] = state_r;
        end else if (hit(adr_i, apc_pkg::OFS_IRQST)) begin
            rdata[2:0] = flag_r;
        end else if (hit(adr_i, apc_pkg::OFS_IRQMK)) begin
            rdata[2:0] = mask_r;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd_stb) begin
            dat_o <= rdata;
        end else begin
            dat_o <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins

    assign pin_o    = pin_o_r;
    assign pin_oe_o = pin_oe_r;

endmodule : apc_top

// ==== include/apc_pkg.sv ====
package apc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // sizes
    localparam int unsigned NPIN   = 3;
    localparam int unsigned AW     = 5;
    localparam int unsigned DW     = 32;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [4:0] OFS_CTL34 = 5'h00;
    localparam logic [4:0] OFS_CTL5  = 5'h04;
    localparam logic [4:0] OFS_STATE = 5'h08;
    localparam logic [4:0] OFS_IRQST = 5'h0C;
    localparam logic [4:0] OFS_IRQMK = 5'h10;

    ////////////////////////////////////////////////////////////////////////////
    // per-pin field positions inside a nibble
    localparam int unsigned FLD_DIR  = 0;
    localparam int unsigned FLD_POL  = 1;
    localparam int unsigned FLD_EDGE = 2;
    localparam int unsigned FLD_OUT  = 3;
    localparam int unsigned NIB_W    = 4;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset; suspend reloads only the two control words
    localparam logic [7:0] RST_CTL34 = 8'h90;
    localparam logic [7:0] RST_CTL5  = 8'h09;
    localparam logic [2:0] RST_MASK  = 3'h0;
    localparam logic [2:0] RST_FLAGS = 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // bus answer latency in cycles after the request is seen
    localparam int unsigned ACK_LAT  = 1;

    ////////////////////////////////////////////////////////////////////////////
    // one pin's settings, msb first as stored in its nibble
    typedef struct packed {
        logic out_lvl;
        logic edge_sns;
        logic pol_high;
        logic dir_out;
    } apc_pin_cfg_s;

    typedef enum logic [0:0] {
        APC_IDLE,
        APC_ACK
    } apc_bus_e;

endpackage : apc_pkg

// ==== tb/apc_checker.sv ====
`timescale 1ns/1ns

module apc_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        suspend_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic [2:0]  pin_o,
    input wire logic [2:0]  pin_oe_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_ack_after_take:
        assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
    a_ack_one_pulse:
        assert property (ack_o |=> !ack_o) else $error("ack too long");
    a_dat_idle_zero:
        assert property (!ack_o |-> dat_o == 32'h0) else $error("data outside ack");
    a_dat_upper_zero:
        assert property (ack_o |-> dat_o[31:8] == 24'h0) else $error("upper data set");
    a_input_not_driven:
        assert property ((pin_o & ~pin_oe_o) == 3'h0) else $error("input pin driven");
    a_reset_pin_dflt:
        assert property (disable iff (1'b0) rst_i [*2] |=> pin_oe_o == 3'h6 && pin_o == 3'h6)
        else $error("reset pin default");
    a_suspend_pin_dflt:
        assert property (suspend_i [*2] |=> pin_oe_o == 3'h6 && pin_o == 3'h6)
        else $error("suspend pin default");
    a_dir_change_cause:
        assert property ($changed(pin_oe_o) |-> $past(ack_o && we_i) || $past(suspend_i, 2)
            || $past(rst_i, 2) || $past(rst_i)) else $error("direction changed alone");
endmodule : apc_checker

bind apc_top apc_checker chk (.*);

// ==== tb/apc_pin_model.sv ====
`timescale 1ns/1ns

module apc_pin_model (
    input  wire logic [2:0] pin_o,
    input  wire logic [2:0] pin_oe_o,
    input  wire logic [2:0] lvl_i,
    output logic      [2:0] pin_i
);
    // a driven pin shows the device level, a released one the board level
    assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & lvl_i);
endmodule : apc_pin_model

// ==== tb/test_aux_pin_config_3_to_5.sv ====
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin fail_count++; \
    $display("ERROR t=%0t got %h exp %h", $time, a, b); end end

module test_aux_pin_config_3_to_5;
    logic        clk_i = 0, rst_i = 1, suspend_i = 0, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [4:0]  adr_i = 0;
    logic [3:0]  sel_i = 0;
    logic [31:0] dat_i = 0, dat_o, rd, r, seed = 32'hadcd;
    logic        ack_o, irq_o;
    logic [2:0]  pin_i, pin_o, pin_oe_o, lvl = 3'h7;
    logic [7:0]  c34, c5;
    int          fail_count = 0, comparisons = 0;

    apc_top dut (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .suspend_i(suspend_i),
        .cyc_i    (cyc_i),
        .stb_i    (stb_i),
        .we_i     (we_i),
        .adr_i    (adr_i),
        .sel_i    (sel_i),
        .dat_i    (dat_i),
        .dat_o    (dat_o),
        .ack_o    (ack_o),
        .irq_o    (irq_o),
        .pin_i    (pin_i),
        .pin_o    (pin_o),
        .pin_oe_o (pin_oe_o)
    );
    apc_pin_model board (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .lvl_i(lvl), .pin_i(pin_i));

    initial forever #5 clk_i = ~clk_i;

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // expected state bits for level sensing: input pins at their asserted level
    function logic [2:0] exp_state(logic [11:0] cfg, logic [2:0] w);
        for (int k = 0; k < 3; k++) exp_state[k] = !cfg[4*k] && (w[k] === cfg[4*k+1]);
    endfunction : exp_state

    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick

    task wb(input logic w, input logic [4:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= {24'h0, d};
        do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 100);
        if (n == 100) fail_count++;
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask : wb

    task rdchk(input logic [4:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h0, rd);
        `CHK(rd, {24'h0, e})
    endtask : rdchk

    task stop_test;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : stop_test

    initial begin
        repeat (5000) @(posedge clk_i);
        fail_count++;
        stop_test();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        tick(2);
        `CHK({pin_oe_o, pin_o}, 6'h36)
        rdchk(apc_pkg::OFS_CTL34, apc_pkg::RST_CTL34);
        rdchk(apc_pkg::OFS_CTL5, apc_pkg::RST_CTL5);
        wb(1'b1, 5'h14, 8'hFF, rd);
        rdchk(5'h14, 8'h00);
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            c34 = r[7:0] & 8'hBB;
            c5 = r[15:8] & 8'h0B;
            lvl <= r[18:16];
            wb(1'b1, apc_pkg::OFS_CTL34, c34, rd);
            wb(1'b1, apc_pkg::OFS_CTL5, c5, rd);
            tick(3);
            `CHK(pin_oe_o, {c5[0], c34[4], c34[0]})
            `CHK(pin_o, {c5[3], c34[7], c34[3]} & {c5[0], c34[4], c34[0]})
            rdchk(apc_pkg::OFS_STATE, {5'h0, exp_state({c5[3:0], c34}, lvl)});
        end
        lvl <= 3'h0;
        wb(1'b1, apc_pkg::OFS_CTL34, 8'h66, rd);
        wb(1'b1, apc_pkg::OFS_CTL5, 8'h06, rd);
        wb(1'b1, apc_pkg::OFS_IRQMK, 8'h07, rd);
        tick(3);
        wb(1'b0, apc_pkg::OFS_STATE, 8'h0, rd);
        wb(1'b0, apc_pkg::OFS_IRQST, 8'h0, rd);
        tick(2);
        `CHK(irq_o, 1'b0)
        @(posedge clk_i) lvl <= 3'h7;
        @(posedge clk_i) lvl <= 3'h0;
        tick(4);
        `CHK(irq_o, 1'b1)
        rdchk(apc_pkg::OFS_STATE, 8'h07);
        rdchk(apc_pkg::OFS_STATE, 8'h00);
        rdchk(apc_pkg::OFS_IRQST, 8'h07);
        tick(2);
        `CHK(irq_o, 1'b0)
        @(posedge clk_i) suspend_i <= 1'b1;
        tick(3);
        @(posedge clk_i) suspend_i <= 1'b0;
        tick(2);
        `CHK({pin_oe_o, pin_o}, 6'h36)
        rdchk(apc_pkg::OFS_CTL34, apc_pkg::RST_CTL34);
        rdchk(apc_pkg::OFS_IRQMK, 8'h07);
        // mid-run reset after pin 5 was turned into an input
        wb(1'b1, apc_pkg::OFS_CTL5, 8'h00, rd);
        @(posedge clk_i) rst_i <= 1'b1;
        tick(3);
        `CHK({pin_oe_o, pin_o}, 6'h36)
        @(posedge clk_i) rst_i <= 1'b0;
        tick(2);
        `CHK({pin_oe_o, pin_o}, 6'h36)
        rdchk(apc_pkg::OFS_CTL5, apc_pkg::RST_CTL5);
        stop_test();
    end
endmodule : test_aux_pin_config_3_to_5
